// ===== pkg/supply_supervisor_params.svh
// Constants for the supply supervisor control block.
// Operation
// - Low-voltage reset enable bit 7 defaults set; resets chip below threshold.
// - Low-voltage detector ignored for 100 us after enabling its reset.
// - Status bit 6 shows supply below threshold; zero while detector disabled.
// - Protected low-power mode bit 5 defaults zero; one selects low current.
// - Interrupt flag bit 4 set on any threshold crossing; writing one clears it; does not drive the interrupt.
// - Action select bit 3: one resets chip, zero interrupts, when below.
// - Action select loads from configuration bit 20 at reset; protected.
// - Brown-out interrupt holds until detector enable is cleared.
// - Threshold select bits 2:1 load from configuration bits 22:21; protected.
// - Detector enable bit 0 loads from configuration bit 23; protected.
// - Disable code equal to 5aa5h suppresses power-on reset.
// - Any other chip reset source returns disable code to non-magic value.
`ifndef SUPPLY_SUPERVISOR_PARAMS_SVH
`define SUPPLY_SUPERVISOR_PARAMS_SVH
`define ADDR_BROWNOUT_CONTROL      12'h018
`define ADDR_POWERON_RESET_CONTROL 12'h024
`define ADDR_PROTECTION_UNLOCK     12'h100
`define UNLOCK_BYTE_0              8'h59
`define UNLOCK_BYTE_1              8'h16
`define UNLOCK_BYTE_2              8'h88
`define BIT_LVR_ENABLE             7
`define BIT_OUTPUT_STATUS          6
`define BIT_LOW_POWER              5
`define BIT_IRQ_FLAG               4
`define BIT_ACTION_SELECT          3
`define BIT_THRESHOLD_HI           2
`define BIT_THRESHOLD_LO           1
`define BIT_DETECTOR_ENABLE        0
`define CFG_BIT_ACTION             20
`define CFG_BIT_THRESHOLD_LO       21
`define CFG_BIT_THRESHOLD_HI       22
`define CFG_BIT_ENABLE             23
`define POR_DISABLE_MAGIC          16'h5aa5
`define POR_CODE_RESET             16'h0000
`define LVR_SETTLE_NS              100000
`define CLK_PERIOD_NS              8
`define LVR_SETTLE_CYCLES          ((`LVR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== pkg/supply_supervisor_pkg.sv
// Types shared by the supply supervisor control block.
package supply_supervisor_pkg;
  typedef enum logic [1:0] {
    unlock_idle = 2'b00,
    unlock_one  = 2'b01,
    unlock_two  = 2'b11,
    unlock_open = 2'b10
  } unlock_state_e;

  typedef struct packed {
    logic       lvr_enable;
    logic       low_power;
    logic       action_select;
    logic [1:0] threshold;
    logic       detector_enable;
  } brownout_cfg_s;

  typedef struct packed {
    logic below_threshold;
    logic below_lvr;
  } analog_status_s;
endpackage

// ===== rtl/protection_unlock.sv
// Unlock sequence tracker for write-protected supervisor bits.
`timescale 1ns/10ps
`include "supply_supervisor_params.svh"
module protection_unlock
  import supply_supervisor_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_byte,
  output wire logic       unlocked
);
  unlock_state_e state;
  unlock_state_e next_state;

  // Each byte must follow in order; any other write restarts the sequence.
  always_comb begin
    next_state = unlock_idle;
    case (state)
      unlock_idle: next_state = (wr_byte == `UNLOCK_BYTE_0) ? unlock_one : unlock_idle;
      unlock_one:  next_state = (wr_byte == `UNLOCK_BYTE_1) ? unlock_two : unlock_idle;
      unlock_two:  next_state = (wr_byte == `UNLOCK_BYTE_2) ? unlock_open : unlock_idle;
      unlock_open: next_state = (wr_byte == `UNLOCK_BYTE_0) ? unlock_one : unlock_idle;
      default:     next_state = unlock_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= unlock_idle;
    end else if (clk_en && wr_stb) begin
      state <= next_state;
    end
  end

  assign unlocked = (state == unlock_open);
endmodule // protection_unlock

// ===== rtl/supply_supervisor_control.sv
// Brown-out, low-voltage and power-on reset control with an APB slave.
`timescale 1ns/10ps
`include "supply_supervisor_params.svh"
module supply_supervisor_control
  import supply_supervisor_pkg::*;
#(
  parameter int LVR_SETTLE_CYCLES = `LVR_SETTLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic [31:0] flash_user_config_word,
  input  wire logic        other_reset_event,
  input  wire logic        brownout_compare_raw,
  input  wire logic        low_voltage_compare_raw,
  output logic             brownout_detector_enable,
  output logic [1:0]       brownout_threshold_select,
  output logic             brownout_low_power_mode,
  output logic             brownout_irq,
  output logic             brownout_chip_reset,
  output logic             low_voltage_chip_reset,
  output logic             poweron_reset_suppress
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  brownout_cfg_s  cfg;
  analog_status_s analog;
  logic           irq_flag;
  logic [15:0]    poweron_reset_disable_code;
  logic           cfg_pending;
  logic           below_prev;
  logic [31:0]    settle_count;
  logic           unlocked;

  wire access_phase = psel && penable;
  wire wr_access    = access_phase && pwrite && clk_en;
  wire sel_bod      = (paddr == `ADDR_BROWNOUT_CONTROL);
  wire sel_por      = (paddr == `ADDR_POWERON_RESET_CONTROL);
  wire sel_unlock   = (paddr == `ADDR_PROTECTION_UNLOCK);
  wire mapped       = sel_bod || sel_por || sel_unlock;
  wire wr_bod       = wr_access && sel_bod && pstrb[0];
  wire wr_por_lo    = wr_access && sel_por && pstrb[0] && unlocked;
  wire wr_por_hi    = wr_access && sel_por && pstrb[1] && unlocked;
  wire wr_unlock    = wr_access && sel_unlock && pstrb[0];
  wire prot_wr      = wr_bod && unlocked;

  assign pready  = 1'b1;
  assign pslverr = access_phase && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  protection_unlock u_unlock (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .wr_stb   (wr_unlock),
    .wr_byte  (pwdata[7:0]),
    .unlocked (unlocked)
  );

  sync_two_flop #(.WIDTH(2)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({brownout_compare_raw, low_voltage_compare_raw}),
    .sync_out (analog)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register.

  // Configuration word is sampled on the first enabled edge after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_pending <= 1'b1;
    end else if (clk_en) begin
      cfg_pending <= 1'b0;
    end
  end

  wire [7:0] wd = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{lvr_enable: 1'b1, low_power: 1'b0, action_select: 1'b0,
               threshold: 2'b00, detector_enable: 1'b0};
    end else if (clk_en) begin
      if (cfg_pending) begin
        cfg.action_select   <= flash_user_config_word[`CFG_BIT_ACTION];
        cfg.threshold       <= {flash_user_config_word[`CFG_BIT_THRESHOLD_HI],
                                flash_user_config_word[`CFG_BIT_THRESHOLD_LO]};
        cfg.detector_enable <= flash_user_config_word[`CFG_BIT_ENABLE];
      end else if (prot_wr) begin
        cfg.lvr_enable      <= wd[`BIT_LVR_ENABLE];
        cfg.low_power       <= wd[`BIT_LOW_POWER];
        cfg.action_select   <= wd[`BIT_ACTION_SELECT];
        cfg.threshold       <= wd[`BIT_THRESHOLD_HI:`BIT_THRESHOLD_LO];
        cfg.detector_enable <= wd[`BIT_DETECTOR_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out detection and interrupt flag.

  wire below       = cfg.detector_enable && analog.below_threshold;
  wire crossing    = cfg.detector_enable && (analog.below_threshold != below_prev);
  wire flag_clear  = wr_bod && wd[`BIT_IRQ_FLAG];
  wire next_flag   = crossing ? 1'b1 : (flag_clear ? 1'b0 : irq_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_prev <= 1'b0;
      irq_flag   <= 1'b0;
    end else if (clk_en) begin
      below_prev <= analog.below_threshold;
      irq_flag   <= next_flag;
    end
  end

  // The interrupt holds while enabled; only clearing the enable drops it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_irq <= 1'b0;
    end else if (clk_en) begin
      if (!cfg.detector_enable) begin
        brownout_irq <= 1'b0;
      end else if (below && !cfg.action_select) begin
        brownout_irq <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_chip_reset <= 1'b0;
    end else if (clk_en) begin
      brownout_chip_reset <= below && cfg.action_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-voltage reset with settling blank.

  wire settled = (settle_count >= LVR_SETTLE_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count           <= 32'h0000_0000;
      low_voltage_chip_reset <= 1'b0;
    end else if (clk_en) begin
      if (!cfg.lvr_enable) begin
        settle_count <= 32'h0000_0000;
      end else if (!settled) begin
        settle_count <= settle_count + 32'h0000_0001;
      end
      low_voltage_chip_reset <= cfg.lvr_enable && settled && analog.below_lvr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset disable code.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poweron_reset_disable_code <= `POR_CODE_RESET;
    end else if (clk_en) begin
      if (other_reset_event) begin
        poweron_reset_disable_code <= `POR_CODE_RESET;
      end else begin
        if (wr_por_lo) begin
          poweron_reset_disable_code[7:0] <= pwdata[7:0];
        end
        if (wr_por_hi) begin
          poweron_reset_disable_code[15:8] <= pwdata[15:8];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poweron_reset_suppress <= 1'b0;
    end else if (clk_en) begin
      poweron_reset_suppress <= (poweron_reset_disable_code == `POR_DISABLE_MAGIC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read data.

  assign brownout_detector_enable  = cfg.detector_enable;
  assign brownout_threshold_select = cfg.threshold;
  assign brownout_low_power_mode   = cfg.low_power;

  wire [31:0] bod_read = {24'h000000, cfg.lvr_enable, below, cfg.low_power, irq_flag,
                          cfg.action_select, cfg.threshold, cfg.detector_enable};
  wire [31:0] por_read = {16'h0000, poweron_reset_disable_code};
  wire [31:0] unl_read = {31'h00000000, unlocked};
  wire [31:0] next_prdata = sel_bod ? bod_read :
                            sel_por ? por_read :
                            sel_unlock ? unl_read : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule // supply_supervisor_control

// ===== rtl/sync_two_flop.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/10ps
module sync_two_flop #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage    <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end
endmodule // sync_two_flop

// ===== verif/analog_supply_model.sv
// Behavioural model of the analog brown-out and low-voltage comparators.
`timescale 1ns/10ps
module analog_supply_model
  import supply_supervisor_pkg::*;
#(
  parameter int LVR_MV  = 2000,
  parameter int SLOW_NS = 40
) (
  input  var int           supply_mv,
  input  wire logic        brownout_detector_enable,
  input  wire logic [1:0]  brownout_threshold_select,
  input  wire logic        brownout_low_power_mode,
  output logic             brownout_compare_raw,
  output logic             low_voltage_compare_raw
);
  int thr_mv;
  assign thr_mv = brownout_threshold_select == 2'b11 ? 4500 :
                  brownout_threshold_select == 2'b10 ? 3800 :
                  brownout_threshold_select == 2'b01 ? 2700 : 2200;
  initial brownout_compare_raw = 1'b0;
  always @* low_voltage_compare_raw = supply_mv < LVR_MV;
  always @(supply_mv, thr_mv, brownout_detector_enable, brownout_low_power_mode)
    brownout_compare_raw <= #(brownout_low_power_mode ? SLOW_NS : 8)
      brownout_detector_enable && supply_mv < thr_mv;
endmodule // analog_supply_model

// ===== verif/supply_supervisor_properties.sv
// Concurrent checks on the supply supervisor control ports.
`timescale 1ns/10ps
module supply_supervisor_properties
  import supply_supervisor_pkg::*;
#(
  parameter int LVR_SETTLE_CYCLES = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        brownout_compare_raw,
  input wire logic        low_voltage_compare_raw,
  input wire logic        other_reset_event,
  input wire logic        brownout_detector_enable,
  input wire logic [1:0]  brownout_threshold_select,
  input wire logic        brownout_low_power_mode,
  input wire logic        brownout_irq,
  input wire logic        brownout_chip_reset,
  input wire logic        low_voltage_chip_reset,
  input wire logic        poweron_reset_suppress
);
  int         cnt;
  logic [1:0] seq;
  wire [7:0]  wb     = pwdata[7:0];
  wire        wr_acc = psel && penable && pwrite && clk_en && pstrb[0];
  wire        wr_ctl = wr_acc && paddr == 12'h018;
  wire        wr_por = wr_acc && paddr == 12'h024;
  wire        wr_unl = wr_acc && paddr == 12'h100;
  // Tracks the unlock bytes so that protected changes can be tied to an open lock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seq <= 2'h0;
    else if (wr_unl) seq <= (seq == 2'h1) ? ((wb == 8'h16) ? 2'h2 : 2'h0) :
                            (seq == 2'h2) ? ((wb == 8'h88) ? 2'h3 : 2'h0) :
                            ((wb == 8'h59) ? 2'h1 : 2'h0);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else if (cnt < LVR_SETTLE_CYCLES + 2) cnt <= cnt + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bo_calm; !brownout_compare_raw [*5]; endsequence
  sequence lv_calm; !low_voltage_compare_raw [*5]; endsequence
  AST_LVR_SETTLE: assert property (cnt < LVR_SETTLE_CYCLES |-> !low_voltage_chip_reset)
    else $error("lvr early");
  AST_LV_CALM: assert property (lv_calm |-> !low_voltage_chip_reset)
    else $error("lvr without low supply");
  AST_BO_CALM: assert property (bo_calm |-> !brownout_chip_reset)
    else $error("bo reset without low supply");
  AST_IRQ_HOLD: assert property (brownout_irq ##1 brownout_detector_enable |-> brownout_irq)
    else $error("irq dropped");
  AST_QUIET: assert property (!brownout_detector_enable [*3]
    |-> !brownout_irq && !brownout_chip_reset) else $error("active while off");
  AST_PROT: assert property (cnt > 1 && $changed({brownout_detector_enable,
    brownout_threshold_select, brownout_low_power_mode}) |-> $past(wr_ctl) && $past(seq) == 2'h3)
    else $error("prot");
  AST_POR_SET: assert property ($rose(poweron_reset_suppress)
    |-> ($past(wr_por) && $past(seq) == 2'h3) || ($past(wr_por, 2) && $past(seq, 2) == 2'h3))
    else $error("por set");
  AST_POR_CLEAR: assert property (other_reset_event |-> ##[1:2] !poweron_reset_suppress)
    else $error("por clear");
endmodule // supply_supervisor_properties

bind supply_supervisor_control supply_supervisor_properties #(
  .LVR_SETTLE_CYCLES(LVR_SETTLE_CYCLES)
) u_props (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .brownout_compare_raw,
  .low_voltage_compare_raw, .other_reset_event, .brownout_detector_enable,
  .brownout_threshold_select, .brownout_low_power_mode, .brownout_irq,
  .brownout_chip_reset, .low_voltage_chip_reset, .poweron_reset_suppress
);

// ===== verif/test_supply_supervisor_control.sv
// Self-checking testbench for the supply supervisor control block.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_supply_supervisor_control
  import supply_supervisor_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        other_reset_event = 1'b0, clk_en = 1'b1, pready, pslverr, rd_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [3:0]  pstrb = 4'h0;
  logic        brownout_compare_raw, low_voltage_compare_raw, brownout_detector_enable;
  logic        brownout_low_power_mode, brownout_irq, brownout_chip_reset;
  logic        low_voltage_chip_reset, poweron_reset_suppress;
  logic [1:0]  brownout_threshold_select;
  int          supply_mv = 5000, fail_count = 0, num_checks = 0;

  supply_supervisor_control #(.LVR_SETTLE_CYCLES(20)) DUT (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .flash_user_config_word(32'h00b0_0000), .other_reset_event,
    .brownout_compare_raw, .low_voltage_compare_raw, .brownout_detector_enable,
    .brownout_threshold_select, .brownout_low_power_mode, .brownout_irq, .brownout_chip_reset,
    .low_voltage_chip_reset, .poweron_reset_suppress
  );
  analog_supply_model ANA (
    .supply_mv, .brownout_detector_enable, .brownout_threshold_select,
    .brownout_low_power_mode, .brownout_compare_raw, .low_voltage_compare_raw
  );

  initial forever #4 pclk = ~pclk;

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= {4{w}};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata; rd_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_data, e)
  endtask
  task automatic supply(input int mv);
    supply_mv = mv;
    repeat (12) @(negedge pclk);
  endtask
  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge pclk);
    fail_count++;
    finish_test;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h018, 32'h8b);
    `CHK({brownout_detector_enable, brownout_threshold_select}, 3'b101)
    rd(12'h024, 32'h0);
    rd(12'h030, 32'h0);
    `CHK(rd_err, 1'b1)
    apb(1'b1, 12'h018, 32'h0);
    rd(12'h018, 32'h8b);
    $display("test reset and lock done");
    apb(1'b1, 12'h100, 32'h59);
    apb(1'b1, 12'h100, 32'h16);
    apb(1'b1, 12'h100, 32'h88);
    rd(12'h018, 32'h8b);
    apb(1'b1, 12'h018, 32'h27);
    rd(12'h018, 32'h27);
    `CHK({brownout_detector_enable, brownout_threshold_select, brownout_low_power_mode}, 4'hf)
    supply(4000);
    rd(12'h018, 32'h77);
    `CHK({brownout_irq, brownout_chip_reset}, 2'b10)
    apb(1'b1, 12'h018, 32'h37);
    rd(12'h018, 32'h67);
    supply(5000);
    rd(12'h018, 32'h37);
    `CHK(brownout_irq, 1'b1)
    apb(1'b1, 12'h018, 32'h26);
    rd(12'h018, 32'h36);
    `CHK(brownout_irq, 1'b0)
    $display("test interrupt done");
    apb(1'b1, 12'h018, 32'h2f);
    supply(4000);
    `CHK({brownout_irq, brownout_chip_reset}, 2'b01)
    rd(12'h018, 32'h7f);
    supply(1500);
    `CHK(low_voltage_chip_reset, 1'b0)
    $display("test brown-out reset done");
    apb(1'b1, 12'h018, 32'ha6);
    repeat (5) @(negedge pclk);
    `CHK({low_voltage_chip_reset, brownout_chip_reset}, 2'b00)
    repeat (30) @(negedge pclk);
    `CHK(low_voltage_chip_reset, 1'b1)
    supply(5000);
    `CHK(low_voltage_chip_reset, 1'b0)
    $display("test low voltage done");
    apb(1'b1, 12'h024, 32'h5aa5);
    settle;
    `CHK(poweron_reset_suppress, 1'b1)
    apb(1'b1, 12'h024, 32'h5aa4);
    settle;
    `CHK(poweron_reset_suppress, 1'b0)
    apb(1'b1, 12'h024, 32'h5aa5);
    @(posedge pclk) other_reset_event <= 1'b1;
    @(posedge pclk) other_reset_event <= 1'b0;
    rd(12'h024, 32'h0);
    settle;
    `CHK(poweron_reset_suppress, 1'b0)
    $display("test power-on disable done");
    rd(12'h100, 32'h1);
    @(posedge pclk) clk_en <= 1'b0;
    apb(1'b1, 12'h024, 32'h5aa5);
    @(posedge pclk) clk_en <= 1'b1;
    rd(12'h024, 32'h0);
    `CHK(poweron_reset_suppress, 1'b0)
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b1, 12'h100, 32'h59);
    apb(1'b1, 12'h100, 32'h88);
    apb(1'b1, 12'h100, 32'h16);
    apb(1'b1, 12'h100, 32'h88);
    rd(12'h100, 32'h0);
    apb(1'b1, 12'h024, 32'h5aa5);
    rd(12'h024, 32'h0);
    apb(1'b1, 12'h018, 32'h9b);
    rd(12'h018, 32'ha6);
    `CHK({brownout_detector_enable, brownout_low_power_mode}, 2'b01)
    $display("test lock done");
    finish_test;
  end
endmodule // test_supply_supervisor_control
